// File: src/edc_ctrl.sv
// Controller that drives the strobes, multiplexed address and data of an EDO page-mode memory.
// Notes on behaviour
// - After reset wait the power-up pause, then run eight column-first refresh cycles.
// - A refresh lapse repeats the eight-cycle wake-up before accesses resume.
// - Both strobes go high for the precharge before every new row cycle.
// - Reads keep the write strobe high through both strobe rises.
// - Writes lower the write strobe before the column strobe: early write, outputs open.
// - Read-write cycles need write strobe late enough; this controller never issues them.
// - Write strobe timing never falls between early write and read-write windows.
// - Write strobe low is the write command; no late writes are generated.
// - Output enable is driven, never tied low; no late writes needed.
// - Output enable stays high during every write.
// - Write data is set up before and held after the column strobe fall.
// - Hidden refresh is not used; refreshes are standalone column-first cycles.
// - Row strobe low time in page mode is bounded by a cycle counter.
// - Row strobe falls are spaced by at least the random cycle time.
// - Page column cycles last at least the page cycle time, fall and rise.
// - Column-first refresh holds column low before and after the row fall.
// - Column strobe stays low at least the low-to-high span.
// - Column strobe falls no sooner than the row-to-column delay.
// - All rows are refreshed within the refresh period, one per interval.
`timescale 1ns/1ps
module edc_ctrl #(
  parameter int POWERUP_CYCLES = edc_pkg::EDC_POWERUP_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire edc_pkg::edc_req_type req_i,
  output logic req_ready_o,
  output logic [edc_pkg::EDC_DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic init_done_o,
  output edc_pkg::edc_pins_type pins_o,
  input wire logic [edc_pkg::EDC_DATA_W-1:0] dq_i
);
  import edc_pkg::*;

  typedef enum logic [3:0] {
    S_BOOT, S_POWER, S_IDLE, S_REFR_CAS, S_REFR_RAS, S_REFR_END,
    S_ROW, S_RAS, S_COLA, S_CAS, S_CASUP, S_RASUP
  } edc_state_type;

  edc_state_type state_reg;
  edc_state_type state_next;
  edc_pins_type pins_reg;
  edc_pins_type pins_next;
  edc_req_type cur_reg;
  edc_req_type cur_next;
  logic [EDC_DATA_W-1:0] rdata_reg;
  logic [EDC_DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [EDC_WAKE_W-1:0] wake_reg;
  logic [EDC_WAKE_W-1:0] wake_next;
  logic init_reg;
  logic init_next;
  logic [EDC_PAGE_W-1:0] page_reg;
  logic [EDC_PAGE_W-1:0] page_next;
  logic step_load;
  logic [EDC_CNT_W-1:0] step_cnt;
  logic step_done;
  logic rc_load;
  logic rc_done;
  logic ref_req;
  logic ref_ack;
  logic lapse;
  logic lapse_clr;
  logic req_ready;
  logic page_hit;

  // Column phase: column address, write strobe and data drive for the operation.
  function automatic edc_pins_type col_pins(input edc_pins_type p, input edc_req_type r);
    edc_pins_type q;
    q = p;
    q.addr = r.col;
    q.we_n = !r.write;
    q.oe_n = r.write;
    q.dq = r.wdata;
    q.dq_oe = r.write;
    return q;
  endfunction

  // Step timer for the current state.
  edc_delay u_step (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(step_load),
    .count_i(step_cnt),
    .done_o(step_done)
  );

  // Row cycle timer, started at every row strobe fall.
  edc_delay u_rc (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(rc_load),
    .count_i(EDC_CNT_W'(EDC_RC_CYC)),
    .done_o(rc_done)
  );

  // Refresh scheduling.
  edc_refresh_timer u_ref (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ack_i(ref_ack),
    .lapse_clr_i(lapse_clr),
    .req_o(ref_req),
    .lapse_o(lapse)
  );

  // A page access is only taken while the row may stay open and no refresh waits.
  assign page_hit = req_valid_i && init_reg && !ref_req && !lapse
                    && (req_i.row == cur_reg.row)
                    && (page_reg < EDC_PAGE_W'(EDC_PAGE_LIMIT));

  // Next-state logic of the sequencer.
  always_comb begin
    state_next = state_reg;
    pins_next = pins_reg;
    cur_next = cur_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    wake_next = wake_reg;
    init_next = init_reg;
    page_next = page_reg;
    step_load = 1'b0;
    step_cnt = '0;
    rc_load = 1'b0;
    ref_ack = 1'b0;
    lapse_clr = 1'b0;
    req_ready = 1'b0;
    // Row-low time is counted so page bursts cannot exceed the longest row pulse.
    if (!pins_reg.ras_n && page_reg != '1) begin
      page_next = page_reg + 1'b1;
    end
    unique case (state_reg)
      S_BOOT: begin
        step_load = 1'b1;
        step_cnt = EDC_CNT_W'(POWERUP_CYCLES);
        state_next = S_POWER;
      end
      S_POWER: begin
        if (step_done) begin
          wake_next = '0;
          lapse_clr = 1'b1;
          pins_next.cas_n = 1'b0;
          pins_next.addr = '0;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_REFR_CAS_CYC);
          state_next = S_REFR_CAS;
        end
      end
      S_IDLE: begin
        if (lapse || ref_req) begin
          // A lapse means row contents may be stale, so the wake-up runs again.
          if (lapse) begin
            wake_next = '0;
            init_next = 1'b0;
            lapse_clr = 1'b1;
          end
          pins_next.cas_n = 1'b0;
          pins_next.addr = '0;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_REFR_CAS_CYC);
          state_next = S_REFR_CAS;
        end else if (req_valid_i && init_reg) begin
          req_ready = 1'b1;
          cur_next = req_i;
          pins_next.addr = req_i.row;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_ROW_CYC);
          state_next = S_ROW;
        end
      end
      S_REFR_CAS: begin
        if (step_done) begin
          pins_next.ras_n = 1'b0;
          rc_load = 1'b1;
          ref_ack = 1'b1;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_REFR_RAS_CYC);
          state_next = S_REFR_RAS;
        end
      end
      S_REFR_RAS: begin
        if (step_done) begin
          pins_next.ras_n = 1'b1;
          pins_next.cas_n = 1'b1;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_RP_CYC);
          state_next = S_REFR_END;
        end
      end
      S_REFR_END: begin
        if (step_done && rc_done) begin
          if (!init_reg && wake_reg != EDC_WAKE_W'(EDC_WAKE_CYCLES - 1)) begin
            wake_next = wake_reg + 1'b1;
            pins_next.cas_n = 1'b0;
            step_load = 1'b1;
            step_cnt = EDC_CNT_W'(EDC_REFR_CAS_CYC);
            state_next = S_REFR_CAS;
          end else begin
            init_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_ROW: begin
        if (step_done && rc_done) begin
          pins_next.ras_n = 1'b0;
          rc_load = 1'b1;
          page_next = '0;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_RAS_CYC);
          state_next = S_RAS;
        end
      end
      S_RAS: begin
        if (step_done) begin
          pins_next = col_pins(pins_reg, cur_reg);
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_COLA_CYC);
          state_next = S_COLA;
        end
      end
      S_COLA: begin
        if (step_done) begin
          pins_next.cas_n = 1'b0;
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_CAS_CYC);
          state_next = S_CAS;
        end
      end
      S_CAS: begin
        if (step_done) begin
          // Sampled at the last edge of the column-low step, after every access time.
          if (!cur_reg.write) begin
            rdata_next = dq_i;
            rvalid_next = 1'b1;
          end
          pins_next.cas_n = 1'b1;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          pins_next.dq_oe = 1'b0;
          step_load = 1'b1;
          if (page_hit) begin
            req_ready = 1'b1;
            cur_next = req_i;
            step_cnt = EDC_CNT_W'(EDC_CASUP_CYC);
            state_next = S_CASUP;
          end else begin
            pins_next.ras_n = 1'b1;
            step_cnt = EDC_CNT_W'(EDC_RP_CYC);
            state_next = S_RASUP;
          end
        end
      end
      S_CASUP: begin
        if (step_done) begin
          pins_next = col_pins(pins_reg, cur_reg);
          step_load = 1'b1;
          step_cnt = EDC_CNT_W'(EDC_COLA_CYC);
          state_next = S_COLA;
        end
      end
      S_RASUP: begin
        if (step_done) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        pins_next = EDC_PINS_IDLE;
        state_next = S_BOOT;
      end
    endcase
  end

  // Register the sequencer state and the pin image.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= S_BOOT;
      pins_reg <= EDC_PINS_IDLE;
      cur_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      wake_reg <= '0;
      init_reg <= 1'b0;
      page_reg <= '0;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      cur_reg <= cur_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      wake_reg <= wake_next;
      init_reg <= init_next;
      page_reg <= page_next;
    end
  end

  // The ready handshake is combinational; everything else leaves a flip-flop.
  assign req_ready_o = req_ready;
  assign rdata_o = rdata_reg;
  assign rdata_valid_o = rvalid_reg;
  assign init_done_o = init_reg;
  assign pins_o = pins_reg;
endmodule

// File: shared/edc_pkg.sv
// Timing constants, widths and carrier types for the page-mode memory controller.
package edc_pkg;

  // Controller clock period.
  localparam int EDC_CLK_NS = 40;
  // Selected speed grade: 0 fastest, 1 middle, 2 slowest.
  localparam int EDC_GRADE = 0;

  typedef int edc_grade_type [3];

  // Device timing in ns, per grade except the single output turn-off maximum.
  localparam edc_grade_type EDC_T_RC_NS = '{60, 90, 110};
  localparam edc_grade_type EDC_T_RAS_NS = '{35, 50, 60};
  localparam edc_grade_type EDC_T_RP_NS = '{20, 30, 40};
  localparam edc_grade_type EDC_T_CAS_NS = '{6, 8, 10};
  localparam edc_grade_type EDC_T_CP_NS = '{5, 8, 10};
  localparam edc_grade_type EDC_T_RCD_NS = '{11, 19, 20};
  localparam edc_grade_type EDC_T_RAH_NS = '{6, 8, 10};
  localparam edc_grade_type EDC_T_CAC_NS = '{10, 14, 15};
  localparam edc_grade_type EDC_T_RAC_NS = '{35, 50, 60};
  localparam edc_grade_type EDC_ACCESS_FROM_COLUMN_PRECHARGE_NS = '{21, 27, 34};
  localparam edc_grade_type EDC_PAGE_CYCLE_TIME_NS = '{12, 20, 25};
  localparam edc_grade_type EDC_T_CSR_NS = '{8, 10, 10};
  localparam edc_grade_type EDC_T_CHR_NS = '{8, 10, 10};
  localparam edc_grade_type EDC_COLUMN_LOW_TO_HIGH_SPAN_NS = '{10, 10, 10};
  localparam edc_grade_type EDC_PAGE_ROW_PULSE_WIDTH_MAX_NS = '{100000, 100000, 100000};
  localparam int EDC_T_OFF_MAX_NS = 15;

  // Least times round up, longest times round down, never below one cycle.
  function automatic int edc_cyc_min(input int ns);
    return ((ns + EDC_CLK_NS - 1) / EDC_CLK_NS < 1) ? 1 : (ns + EDC_CLK_NS - 1) / EDC_CLK_NS;
  endfunction

  function automatic int edc_cyc_max(input int ns);
    return (ns / EDC_CLK_NS < 1) ? 1 : ns / EDC_CLK_NS;
  endfunction

  function automatic int edc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Power-up pause, wake-up length and refresh budget.
  localparam int EDC_POWERUP_NS = 200000;
  localparam int EDC_POWERUP_CYC = edc_cyc_min(EDC_POWERUP_NS);
  localparam int EDC_WAKE_CYCLES = 8;
  localparam int EDC_REF_ROWS = 1024;
  localparam int EDC_REFRESH_PERIOD_NS = 16000000;
  localparam int EDC_REF_INT_CYC = edc_cyc_max(EDC_REFRESH_PERIOD_NS / EDC_REF_ROWS);
  localparam int EDC_REF_OWED_MAX = 4;

  // Step lengths in cycles.
  localparam int EDC_RAS_CYC = edc_max(edc_cyc_min(EDC_T_RAH_NS[EDC_GRADE]),
                                       edc_cyc_min(EDC_T_RCD_NS[EDC_GRADE]));
  localparam int EDC_CASUP_CYC = edc_max(edc_cyc_min(EDC_T_CP_NS[EDC_GRADE]),
                                         edc_cyc_min(EDC_T_OFF_MAX_NS));
  localparam int EDC_CAS_CYC = edc_max(
    edc_max(edc_cyc_min(EDC_T_CAS_NS[EDC_GRADE]), edc_cyc_min(EDC_T_CAC_NS[EDC_GRADE])),
    edc_max(edc_max(edc_cyc_min(EDC_COLUMN_LOW_TO_HIGH_SPAN_NS[EDC_GRADE]),
                    edc_cyc_min(EDC_T_RAC_NS[EDC_GRADE]) - EDC_RAS_CYC - 1),
            edc_max(edc_cyc_min(EDC_ACCESS_FROM_COLUMN_PRECHARGE_NS[EDC_GRADE]) - EDC_CASUP_CYC,
                    edc_cyc_min(EDC_PAGE_CYCLE_TIME_NS[EDC_GRADE]) - EDC_CASUP_CYC)));
  localparam int EDC_REFR_CAS_CYC = edc_cyc_min(EDC_T_CSR_NS[EDC_GRADE]);
  localparam int EDC_REFR_RAS_CYC = edc_max(edc_cyc_min(EDC_T_RAS_NS[EDC_GRADE]),
                                            edc_cyc_min(EDC_T_CHR_NS[EDC_GRADE]));
  localparam int EDC_RP_CYC = edc_cyc_min(EDC_T_RP_NS[EDC_GRADE]);
  localparam int EDC_RC_CYC = edc_cyc_min(EDC_T_RC_NS[EDC_GRADE]);
  localparam int EDC_COLA_CYC = 1;
  localparam int EDC_ROW_CYC = 1;
  localparam int EDC_PAGE_LIMIT = edc_cyc_max(EDC_PAGE_ROW_PULSE_WIDTH_MAX_NS[EDC_GRADE])
                                  - (EDC_CASUP_CYC + EDC_COLA_CYC + EDC_CAS_CYC) - 1;

  // Widths.
  localparam int EDC_CNT_W = 13;
  localparam int EDC_ADDR_W = 10;
  localparam int EDC_DATA_W = 4;
  localparam int EDC_PAGE_W = 12;
  localparam int EDC_REF_W = 9;
  localparam int EDC_OWED_W = 3;
  localparam int EDC_WAKE_W = 4;

  typedef struct packed {
    logic write;
    logic [EDC_ADDR_W-1:0] row;
    logic [EDC_ADDR_W-1:0] col;
    logic [EDC_DATA_W-1:0] wdata;
  } edc_req_type;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [EDC_ADDR_W-1:0] addr;
    logic [EDC_DATA_W-1:0] dq;
    logic dq_oe;
  } edc_pins_type;

  localparam edc_pins_type EDC_PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                             oe_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};

endpackage

// File: src/edc_delay.sv
// Loadable down-counter that times one controller step.
`timescale 1ns/1ps
module edc_delay (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [edc_pkg::EDC_CNT_W-1:0] count_i,
  output logic done_o
);
  import edc_pkg::*;

  logic [EDC_CNT_W-1:0] cnt_reg;
  logic [EDC_CNT_W-1:0] cnt_next;

  // A load of N keeps done low for N-1 cycles, so a step lasts N cycles.
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = (count_i == '0) ? '0 : count_i - 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Register the count.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg == '0);
endmodule

// File: src/edc_refresh_timer.sv
// Refresh interval timer with an owed-refresh count and a lapse flag.
`timescale 1ns/1ps
module edc_refresh_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ack_i,
  input wire logic lapse_clr_i,
  output logic req_o,
  output logic lapse_o
);
  import edc_pkg::*;

  logic [EDC_REF_W-1:0] int_reg;
  logic [EDC_REF_W-1:0] int_next;
  logic [EDC_OWED_W-1:0] owed_reg;
  logic [EDC_OWED_W-1:0] owed_next;
  logic lapse_reg;
  logic lapse_next;
  logic tick;

  // One row is owed every interval; a backlog past the limit means rows went stale.
  always_comb begin
    tick = (int_reg == EDC_REF_W'(EDC_REF_INT_CYC - 1));
    int_next = tick ? '0 : int_reg + 1'b1;
    owed_next = owed_reg;
    if (tick && !ack_i && owed_reg != EDC_OWED_W'(EDC_REF_OWED_MAX)) begin
      owed_next = owed_reg + 1'b1;
    end else if (!tick && ack_i && owed_reg != '0) begin
      owed_next = owed_reg - 1'b1;
    end
    // A lapse arriving with the clear still sets the flag.
    lapse_next = lapse_clr_i ? 1'b0 : lapse_reg;
    if (tick && owed_reg == EDC_OWED_W'(EDC_REF_OWED_MAX)) begin
      lapse_next = 1'b1;
    end
  end

  // Register the timer state.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      int_reg <= '0;
      owed_reg <= '0;
      lapse_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
      owed_reg <= owed_next;
      lapse_reg <= lapse_next;
    end
  end

  assign req_o = (owed_reg != '0);
  assign lapse_o = lapse_reg;
endmodule

// File: testbench/edc_ctrl_checker.sv
// Concurrent checks on the strobes, data drive and request port of the memory controller.
`timescale 1ns/1ps
module edc_ctrl_checker #(
  parameter int POWERUP_CYCLES = 5000
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire edc_pkg::edc_req_type req_i,
  input wire logic req_ready_o,
  input wire logic [edc_pkg::EDC_DATA_W-1:0] rdata_o,
  input wire logic rdata_valid_o,
  input wire logic init_done_o,
  input wire edc_pkg::edc_pins_type pins_o,
  input wire logic [edc_pkg::EDC_DATA_W-1:0] dq_i
);
  import edc_pkg::*;
  logic [EDC_CNT_W-1:0] low_reg;
  logic [EDC_CNT_W-1:0] low_next;
  logic [EDC_CNT_W-1:0] boot_reg;
  logic [EDC_CNT_W-1:0] boot_next;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Counts row-low cycles; only a long run of page hits can push it near the limit.
  // The second count runs from reset and stops once the power-up pause is over.
  always_comb begin
    low_next = pins_o.ras_n ? '0 : low_reg + 1'b1;
    boot_next = (boot_reg < EDC_CNT_W'(POWERUP_CYCLES)) ? boot_reg + 1'b1 : boot_reg;
  end

  always_ff @(posedge clk_i) begin
    low_reg <= nrst_i ? low_next : '0;
    boot_reg <= nrst_i ? boot_next : '0;
  end

  chk_ready_after_init: assert property (req_ready_o |-> init_done_o)
    else $error("request taken before wake-up finished");
  chk_wake_no_access: assert property (!init_done_o |-> pins_o.we_n && pins_o.oe_n)
    else $error("access strobes moved during wake-up");
  chk_early_write_order: assert property ($fell(pins_o.cas_n) && !pins_o.ras_n && !pins_o.we_n
    |-> $past(pins_o.we_n) == 1'b0 && pins_o.dq_oe && $stable(pins_o.dq))
    else $error("write strobe or data not ready before column fall");
  chk_write_gate_high: assert property (!pins_o.we_n |-> pins_o.oe_n)
    else $error("output enable low during a write");
  chk_read_we_high: assert property ($rose(pins_o.cas_n) && $past(pins_o.oe_n) == 1'b0
    |-> $past(pins_o.we_n) && pins_o.we_n)
    else $error("write strobe not high through read column rise");
  chk_column_first: assert property ($fell(pins_o.ras_n) && !pins_o.cas_n
    |-> $past(pins_o.cas_n) == 1'b0 && pins_o.addr == '0 && !pins_o.dq_oe)
    else $error("column-first refresh strobes or address wrong");
  chk_cas_after_row: assert property ($fell(pins_o.cas_n) && !pins_o.ras_n
    |-> $past(pins_o.ras_n) == 1'b0)
    else $error("column strobe fell with the row strobe");
  chk_row_spacing: assert property ($fell(pins_o.ras_n) |=> !$fell(pins_o.ras_n))
    else $error("row strobe falls too close together");
  chk_page_spacing: assert property ($fell(pins_o.cas_n) |=> !$fell(pins_o.cas_n))
    else $error("column strobe falls too close together");
  chk_row_low_limit: assert property (!pins_o.ras_n |-> low_reg < 13'd2500)
    else $error("row strobe held low too long");
  chk_drive_released: assert property ($rose(pins_o.dq_oe)
    |-> $past(pins_o.oe_n) == 1'b1 && !pins_o.we_n)
    else $error("data driven while memory may still drive");
  chk_read_pulse: assert property (rdata_valid_o |=> !rdata_valid_o)
    else $error("read data strobe longer than one cycle");
  chk_boot_pause: assert property ($fell(pins_o.ras_n) |-> boot_reg >= POWERUP_CYCLES)
    else $error("row strobe fell before the power-up pause ended");

  cover property ($fell(pins_o.ras_n) && !pins_o.cas_n);
  cover property ($fell(pins_o.cas_n) && !pins_o.we_n);
  cover property (rdata_valid_o);
endmodule

bind edc_ctrl edc_ctrl_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
  .init_done_o(init_done_o), .pins_o(pins_o), .dq_i(dq_i));

// File: testbench/edc_mem_model.sv
// Behavioural EDO page-mode memory that answers the controller's pins.
`timescale 1ns/1ps
module edc_mem_model #(
  parameter int ACCESS_NS = 10,
  parameter int OFF_NS = 15
) (
  input wire edc_pkg::edc_pins_type pins_i,
  output logic [edc_pkg::EDC_DATA_W-1:0] dq_o
);
  import edc_pkg::*;
  logic [EDC_DATA_W-1:0] mem [int];
  logic [EDC_ADDR_W-1:0] row_reg = '0;
  logic [EDC_DATA_W-1:0] out_reg = '0;
  logic rd_on = 1'b0;
  logic in_refresh = 1'b0;

  // A low column strobe at the row fall means refresh from the internal row counter.
  always @(negedge pins_i.ras_n) begin
    in_refresh = !pins_i.cas_n;
    if (in_refresh) begin
      rd_on = 1'b0;
    end else begin
      row_reg = pins_i.addr;
    end
  end

  // Early write stores at the column fall; a read shows garbage until access time.
  always @(negedge pins_i.cas_n) begin
    if (!pins_i.ras_n && !in_refresh) begin
      if (!pins_i.we_n) begin
        mem[int'({row_reg, pins_i.addr})] = pins_i.dq;
        rd_on = 1'b0;
      end else begin
        out_reg = ~out_reg;
        out_reg <= #ACCESS_NS (mem.exists(int'({row_reg, pins_i.addr})) ?
                               mem[int'({row_reg, pins_i.addr})] : 4'h5);
        rd_on = 1'b1;
      end
    end
  end

  // Output enable rising releases at once; both strobes high release after the off delay.
  always @(posedge pins_i.ras_n or posedge pins_i.cas_n or posedge pins_i.oe_n
           or negedge pins_i.we_n) begin
    if (pins_i.oe_n || !pins_i.we_n) begin
      rd_on = 1'b0;
    end else if (pins_i.ras_n && pins_i.cas_n) begin
      rd_on <= #OFF_NS 1'b0;
    end
  end

  // A released bus shows the inverse of the last word, so stale data never passes.
  assign dq_o = (rd_on && !pins_i.oe_n) ? out_reg : ~out_reg;
endmodule

// File: testbench/edc_ctrl_tb.sv
// Self-checking bench for the page-mode memory controller against a behavioural memory.
`timescale 1ns/1ps
module edc_ctrl_tb;
  import edc_pkg::*;
  localparam int PWR = 20;
  logic clk_i = 1'b0;
  logic nrst_i;
  logic req_valid_i = 1'b0;
  edc_req_type req_i = '0;
  logic req_ready_o;
  logic rdata_valid_o;
  logic init_done_o;
  logic [EDC_DATA_W-1:0] rdata_o;
  logic [EDC_DATA_W-1:0] dq_i;
  edc_pins_type pins_o;
  int err_total = 0;
  int comparisons = 0;
  int refr_total = 0;
  int cyc = 0;
  int rel = 0;
  int first_refr = -1;
  logic ras_prev = 1'b1;
  logic [EDC_DATA_W-1:0] rq [$];
  logic [EDC_DATA_W-1:0] tbl [4] = '{4'h3, 4'hc, 4'ha, 4'h5};
  logic [EDC_ADDR_W-1:0] cols [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};

  always #20 clk_i = ~clk_i;

  edc_ctrl #(.POWERUP_CYCLES(PWR)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .init_done_o(init_done_o), .pins_o(pins_o), .dq_i(dq_i));

  // A slow memory: data arrives late in the column step, not at the earliest moment.
  edc_mem_model #(.ACCESS_NS(35), .OFF_NS(15)) u_mem (.pins_i(pins_o), .dq_o(dq_i));

  // Watch pins on the falling edge, where the registered outputs have settled.
  always @(negedge clk_i) begin
    cyc++;
    if (ras_prev && !pins_o.ras_n && !pins_o.cas_n) begin
      refr_total++;
      if (first_refr < 0) first_refr = cyc;
    end
    ras_prev = pins_o.ras_n;
    if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    err_total++;
    $display("unexpected %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  // Reset is held for eight cycles; the pins and flags must be idle when it ends.
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    chk("pins in reset", pins_o, EDC_PINS_IDLE);
    chk("flags in reset", {init_done_o, req_ready_o, rdata_valid_o}, 3'b000);
    nrst_i = 1'b1;
    #1;
    rel = cyc;
    first_refr = -1;
    refr_total = 0;
  endtask

  // Wake-up: pause first, then exactly eight column-first refreshes before any access.
  task automatic t_wake();
    int n;
    n = 0;
    while (init_done_o !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 2000) timeout("wake-up");
    end
    chk("wake refreshes", refr_total, 8);
    chk("power-up pause", (first_refr - rel) >= PWR, 1);
  endtask

  // Caller sits at a falling edge; valid stays high on return so requests can chain.
  task automatic issue(input logic wr, input logic [EDC_ADDR_W-1:0] row,
                       input logic [EDC_ADDR_W-1:0] col, input logic [EDC_DATA_W-1:0] wd);
    req_valid_i = 1'b1;
    req_i = '{write: wr, row: row, col: col, wdata: wd};
    repeat (500) begin
      #1;
      if (req_ready_o === 1'b1) break;
      @(negedge clk_i);
    end
    if (req_ready_o !== 1'b1) timeout("request taken");
    @(negedge clk_i);
  endtask

  task automatic idle();
    req_valid_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Writes four words back to back, reads them back back to back, compares in order.
  task automatic burst(input logic [EDC_ADDR_W-1:0] r0, input logic [EDC_ADDR_W-1:0] rstep);
    int n;
    rq.delete();
    for (int i = 0; i < 4; i++) issue(1'b1, r0 + rstep * i, cols[i], tbl[i]);
    idle();
    for (int i = 0; i < 4; i++) issue(1'b0, r0 + rstep * i, cols[i], 4'h0);
    idle();
    n = 0;
    while (rq.size() < 4) begin
      @(negedge clk_i);
      n++;
      if (n > 500) timeout("read data");
    end
    for (int i = 0; i < 4; i++) chk("read back", rq[i], tbl[i]);
  endtask

  // Different rows each time: every access is a full random cycle.
  task automatic t_random();
    burst(10'h001, 10'h155);
  endtask

  // One row with boundary columns: page hits keep the row open.
  task automatic t_page();
    burst(10'h3ff, 10'h000);
  endtask

  // Sitting idle past one refresh interval must bring a refresh, and data must survive.
  task automatic t_refresh();
    int c0;
    c0 = refr_total;
    repeat (400) @(negedge clk_i);
    chk("periodic refresh", (refr_total - c0) >= 1, 1);
    rq.delete();
    issue(1'b0, 10'h3ff, cols[1], 4'h0);
    idle();
    repeat (20) @(negedge clk_i);
    chk("reads after refresh", rq.size(), 1);
    chk("data after refresh", rq.size() > 0 ? rq[0] : 4'hx, tbl[1]);
  endtask

  // Reset lands right after a write is taken, then the full wake-up must repeat.
  task automatic t_midreset();
    issue(1'b1, 10'h200, 10'h011, 4'h9);
    req_valid_i = 1'b0;
    do_reset();
    t_wake();
    burst(10'h2a0, 10'h001);
  endtask

  initial begin
    do_reset();
    t_wake();
    t_random();
    t_page();
    t_refresh();
    t_midreset();
    tally_and_finish();
  end
endmodule
